// ==== sdram_refresh_scheduling_tb.sv ====
// refresh scheduling testbench
`timescale 1ns/1ps
`default_nettype none
module sdram_refresh_scheduling_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic rst_cmd = 1'b0;
  logic sr_exit = 1'b0;
  logic [7:0] act = 8'h00;
  logic cs_n;
  logic [3:0] cbits;
  logic [2:0] cnt;
  logic [7:0] blk;
  logic busy, wbusy, done, perr;
  int fails = 0;
  int compares = 0;
  initial forever #12.5 clk_i = ~clk_i;
  sdrref_ctrl_model ctl_u (.clk_i(clk_i), .cs_n_o(cs_n), .bits_o(cbits));
  sdrref_core dut_u (.clk_i(clk_i), .srst_i(srst_i), .chip_select_n_i(cs_n),
    .command_bits_i(cbits), .reset_cmd_i(rst_cmd), .self_refresh_exit_i(sr_exit),
    .bank_active_i(act), .bank_counter_o(cnt), .bank_blocked_o(blk),
    .refresh_busy_o(busy), .whole_array_busy_o(wbusy), .refresh_done_o(done),
    .protocol_error_o(perr));
  task automatic summarize;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // sel 0 watches busy, 1 the error pulse, 2 the done pulse; a hang ends the run
  task automatic wait_for(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? busy : (sel == 1) ? perr : done) !== v && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (((sel == 0) ? busy : (sel == 1) ? perr : done) !== v) begin
      fails++;
      summarize();
    end
  endtask
  task automatic do_ref(input logic whole);
    logic [7:0] eb;
    eb = whole ? 8'hFF : 8'h01 << ctl_u.bank;
    ctl_u.refresh(whole);
    wait_for(0, 1'b1);
    chk(blk, eb);
    chk({7'h00, wbusy}, {7'h00, whole});
    chk({5'h00, cnt}, {5'h00, ctl_u.bank});
    wait_for(2, 1'b1);
    chk({7'h00, done}, 8'h01);
    wait_for(0, 1'b0);
    chk(blk, 8'h00);
  endtask
  task automatic clear(input logic exit_sr);
    rst_cmd = !exit_sr;
    sr_exit = exit_sr;
    @(negedge clk_i);
    rst_cmd = 1'b0;
    sr_exit = 1'b0;
    repeat (5) @(negedge clk_i);
    chk({5'h00, cnt}, 8'h00);
    ctl_u.resync();
  endtask
  task automatic s_round;
    repeat (9) do_ref(1'b0);
  endtask
  task automatic s_whole;
    repeat (3) do_ref(1'b0);
    do_ref(1'b1);
    do_ref(1'b0);
  endtask
  task automatic s_clear;
    repeat (2) do_ref(1'b0);
    clear(1'b0);
    do_ref(1'b0);
    clear(1'b1);
  endtask
  // a second refresh while busy is refused and leaves the counter alone
  task automatic s_refused;
    ctl_u.refresh(1'b1);
    wait_for(0, 1'b1);
    ctl_u.send(4'h4);
    wait_for(1, 1'b1);
    chk({7'h00, perr}, 8'h01);
    wait_for(0, 1'b0);
    chk({5'h00, cnt}, 8'h00);
  endtask
  // refresh onto an active bank is flagged; counter resynced after
  task automatic s_active;
    act = 8'h01 << ctl_u.bank;
    ctl_u.refresh(1'b0);
    wait_for(1, 1'b1);
    chk({7'h00, perr}, 8'h01);
    repeat (12) @(negedge clk_i);
    act = 8'h00;
    clear(1'b0);
  endtask
  task automatic s_decode;
    logic [3:0] tbl [3] = '{4'h0, 4'h5, 4'hB};
    foreach (tbl[i]) begin
      ctl_u.send(tbl[i]);
      repeat (6) @(negedge clk_i);
      chk({7'h00, busy}, 8'h00);
      chk({5'h00, cnt}, 8'h00);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    srst_i = 1'b0;
    s_round();
    s_whole();
    s_clear();
    s_refused();
    s_active();
    s_decode();
    summarize();
  end
endmodule
`default_nettype wire

// ==== sdrref_consts.svh ====
// constants for the refresh scheduling block
`ifndef SDRREF_CONSTS_SVH
`define SDRREF_CONSTS_SVH
`define SDRREF_CLK_PERIOD_PS 25000
`define SDRREF_PB_CYCLE_NS 90
`define SDRREF_AB_CYCLE_NS 130
`define SDRREF_PB_CYCLES \
  ((`SDRREF_PB_CYCLE_NS * 1000 + `SDRREF_CLK_PERIOD_PS - 1) / `SDRREF_CLK_PERIOD_PS)
`define SDRREF_AB_CYCLES \
  ((`SDRREF_AB_CYCLE_NS * 1000 + `SDRREF_CLK_PERIOD_PS - 1) / `SDRREF_CLK_PERIOD_PS)
`define SDRREF_NUM_BANKS 8
`define SDRREF_BANK_ZERO 3'h0
`endif

// ==== sdrref_core.sv ====
// refresh command decode, bank counter and bank state for the device side
`include "sdrref_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sdrref_core
  import sdrref_pkg::*;
#(
  parameter int NUM_BANKS = `SDRREF_NUM_BANKS,
  parameter int PB_CYCLES = `SDRREF_PB_CYCLES,
  parameter int AB_CYCLES = `SDRREF_AB_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic chip_select_n_i,
  input wire logic [3:0] command_bits_i,
  input wire logic reset_cmd_i,
  input wire logic self_refresh_exit_i,
  input wire logic [NUM_BANKS-1:0] bank_active_i,
  output logic [2:0] bank_counter_o,
  output logic [NUM_BANKS-1:0] bank_blocked_o,
  output logic refresh_busy_o,
  output logic whole_array_busy_o,
  output logic refresh_done_o,
  output logic protocol_error_o
);
  logic [1:0] cs_sync;
  logic [3:0] cmd_meta;
  logic [3:0] cmd_sync;
  logic [NUM_BANKS-1:0] act_meta;
  logic [NUM_BANKS-1:0] act_sync;
  logic [1:0] rst_sync;
  logic [1:0] sre_sync;
  sdrref_cmd_t cmd;
  sdrref_state_t state;
  logic [2:0] target;
  logic tmr_load;
  logic [7:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;

  function automatic sdrref_cmd_t decode(input logic cs_n, input logic [3:0] ca);
    if (cs_n) begin
      decode = SDRREF_CMD_NONE;
    end else if (ca[2:0] == 3'h4) begin
      decode = ca[3] ? SDRREF_CMD_AB : SDRREF_CMD_PB;
    end else begin
      decode = SDRREF_CMD_OTHER;
    end
  endfunction

  // pins come from the command clock's far side, so two stages first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cs_sync <= 2'h3;
      cmd_meta <= 4'h0;
      cmd_sync <= 4'h0;
      act_meta <= '0;
      act_sync <= '0;
      rst_sync <= 2'h0;
      sre_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[0], chip_select_n_i};
      cmd_meta <= command_bits_i;
      cmd_sync <= cmd_meta;
      act_meta <= bank_active_i;
      act_sync <= act_meta;
      rst_sync <= {rst_sync[0], reset_cmd_i};
      sre_sync <= {sre_sync[0], self_refresh_exit_i};
    end
  end

  assign cmd = decode(cs_sync[1], cmd_sync);
  // a new refresh is only accepted when no refresh cycle is running
  assign tmr_load = (state == SDRREF_ST_IDLE) &&
                    (cmd == SDRREF_CMD_PB || cmd == SDRREF_CMD_AB);
  assign tmr_count = (cmd == SDRREF_CMD_AB) ? 8'(AB_CYCLES) : 8'(PB_CYCLES);

  sdrref_timer #(.WIDTH(8)) u_timer (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  // bank counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bank_counter_o <= `SDRREF_BANK_ZERO;
    end else if (rst_sync[1] || sre_sync[1]) begin
      bank_counter_o <= `SDRREF_BANK_ZERO;
    end else if (tmr_load && cmd == SDRREF_CMD_AB) begin
      bank_counter_o <= `SDRREF_BANK_ZERO;
    end else if (tmr_load && cmd == SDRREF_CMD_PB) begin
      bank_counter_o <= bank_counter_o + 3'h1;
    end
  end

  // refresh state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= SDRREF_ST_IDLE;
      target <= 3'h0;
    end else begin
      case (state)
        SDRREF_ST_IDLE: begin
          if (tmr_load && cmd == SDRREF_CMD_PB) begin
            state <= SDRREF_ST_PB;
            target <= bank_counter_o;
          end else if (tmr_load) begin
            state <= SDRREF_ST_AB;
          end
        end
        SDRREF_ST_PB, SDRREF_ST_AB: begin
          if (!tmr_busy) begin
            state <= SDRREF_ST_IDLE;
          end
        end
        default: state <= SDRREF_ST_IDLE;
      endcase
    end
  end

  // outputs, all registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bank_blocked_o <= '0;
      refresh_busy_o <= 1'b0;
      whole_array_busy_o <= 1'b0;
      refresh_done_o <= 1'b0;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_blocked_o[b] <= (state == SDRREF_ST_AB && tmr_busy) ||
                             (state == SDRREF_ST_PB && tmr_busy && target == 3'(b));
      end
      refresh_busy_o <= tmr_busy;
      whole_array_busy_o <= (state == SDRREF_ST_AB) && tmr_busy;
      refresh_done_o <= tmr_done;
    end
  end

  // flags a refresh that lands on a busy device or an active bank; one on a busy
  // device is not accepted, one on an active bank still runs and is only reported
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      protocol_error_o <= 1'b0;
    end else if (cmd == SDRREF_CMD_AB) begin
      protocol_error_o <= (state != SDRREF_ST_IDLE) || (act_sync != '0);
    end else if (cmd == SDRREF_CMD_PB) begin
      protocol_error_o <= (state != SDRREF_ST_IDLE) || act_sync[bank_counter_o];
    end else begin
      protocol_error_o <= 1'b0;
    end
  end

  counter_wrap_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (tmr_load && cmd == SDRREF_CMD_PB && !rst_sync[1] && !sre_sync[1] &&
     bank_counter_o == 3'h7) |=> bank_counter_o == 3'h0)
    else $error("bank counter did not wrap to zero");
  counter_step_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (tmr_load && cmd == SDRREF_CMD_PB && !rst_sync[1] && !sre_sync[1]) |=>
    bank_counter_o == $past(bank_counter_o) + 3'h1)
    else $error("bank counter did not advance");
  ab_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (tmr_load && cmd == SDRREF_CMD_AB) |=> bank_counter_o == 3'h0)
    else $error("whole array refresh left counter nonzero");
  sync_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (rst_sync[1] || sre_sync[1]) |=> bank_counter_o == 3'h0)
    else $error("reset or exit did not clear counter");
  decode_ab_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!cs_sync[1] && cmd_sync == 4'hC) |-> cmd == SDRREF_CMD_AB)
    else $error("whole array refresh not decoded");
  pb_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (tmr_load && cmd == SDRREF_CMD_PB) ##1 1 |=>
    bank_blocked_o == (NUM_BANKS'(1) << $past(bank_counter_o, 2)))
    else $error("wrong bank blocked during single bank refresh");
  pb_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (tmr_load && cmd == SDRREF_CMD_PB) |-> ##[1:40] state == SDRREF_ST_IDLE)
    else $error("single bank refresh did not end idle");
  ab_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (tmr_load && cmd == SDRREF_CMD_AB) |-> ##[1:40] state == SDRREF_ST_IDLE)
    else $error("whole array refresh did not end idle");
endmodule
`default_nettype wire

// ==== sdrref_ctrl_model.sv ====
// controller-side model that issues refresh commands
`include "sdrref_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sdrref_ctrl_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic [3:0] bits_o
);
  // controller copy of the device bank counter
  logic [2:0] bank = 3'h0;
  // cycle count starts high so the empty burst history looks old
  int unsigned cyc = 1000;
  int unsigned last = 0;
  logic last_whole = 1'b0;
  int unsigned ab_t [8] = '{default: 0};
  int ab_i = 0;
  // windows outlast any run, so only refresh units are counted here
  int unsigned units = 0;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
  end
  task automatic resync;
    bank = 3'h0;
  endtask
  initial begin
    cs_n_o = 1'b1;
    bits_o = 4'hB;
  end
  // one command cycle; released lines flip so a stale command never looks valid
  task automatic send(input logic [3:0] b);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    bits_o = b;
    @(negedge clk_i);
    cs_n_o = 1'b1;
    bits_o = ~b;
  endtask
  // no activates or precharges are modelled, so the refresh gap covers them
  task automatic refresh(input logic whole);
    int unsigned gap;
    gap = last_whole ? `SDRREF_AB_CYCLES : `SDRREF_PB_CYCLES;
    while (cyc - last < gap) begin
      @(negedge clk_i);
    end
    if (whole) begin
      while (cyc - ab_t[ab_i] < 4 * 8 * `SDRREF_AB_CYCLES) begin
        @(negedge clk_i);
      end
      ab_t[ab_i] = cyc;
      ab_i = (ab_i + 1) % 8;
    end
    last = cyc;
    last_whole = whole;
    units = units + (whole ? 8 : 1);
    send({whole, 3'h4});
    bank = whole ? 3'h0 : bank + 3'h1;
  endtask
endmodule
`default_nettype wire

// ==== sdrref_pkg.sv ====
// types for the refresh scheduling block
package sdrref_pkg;
  typedef enum logic [1:0] {
    SDRREF_CMD_NONE = 2'b00,
    SDRREF_CMD_PB = 2'b01,
    SDRREF_CMD_AB = 2'b10,
    SDRREF_CMD_OTHER = 2'b11
  } sdrref_cmd_t;
  typedef enum logic [1:0] {
    SDRREF_ST_IDLE = 2'b00,
    SDRREF_ST_PB = 2'b01,
    SDRREF_ST_AB = 2'b10
  } sdrref_state_t;
endpackage

// ==== sdrref_timer.sv ====
// down counter that marks a refresh cycle busy
`timescale 1ns/1ps
`default_nettype none
module sdrref_timer #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  logic [WIDTH-1:0] remain;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      remain <= '0;
      done_o <= 1'b0;
    end else if (load_i) begin
      remain <= count_i;
      done_o <= 1'b0;
    end else begin
      done_o <= (remain == {{(WIDTH-1){1'b0}}, 1'b1});
      if (remain != '0) begin
        remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
  assign busy_o = (remain != '0);
endmodule
`default_nettype wire
